//--- design/eeprom_pkg.sv
// constants, state codes and field layout shared by the serial eeprom design
package eeprom_pkg;
  // ==========================================================
  // timing
  localparam int CLK_NS = 20;
  localparam int T_PROG_NS = 5000000; // longest programming time, 5 ms
  localparam int PROG_CYCLES_DEF = T_PROG_NS / CLK_NS; // rounds down
  // ==========================================================
  // array and word layout
  localparam int ADDR_W = 14;
  localparam int PAGE_W = 6;
  localparam int ROW_W = ADDR_W - PAGE_W;
  localparam int STRAP_W = 3;
  localparam logic [3:0] DEV_CODE = 4'ha;
  localparam logic [3:0] LAST_BIT = 4'h8; // rising edges in one word
  localparam logic [3:0] LAST_SHIFT = 4'h7; // falling edges after first bit
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_W = PAGE_W + 8; // page offset then data byte
  // ==========================================================
  // bus sequencer states
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX = 6'h02,
    ST_ACK = 6'h04,
    ST_TX = 6'h08,
    ST_RACK = 6'h10,
    ST_PROG = 6'h20
  } bus_state_e;
  // which word of a command is being received
  typedef enum logic [3:0] {
    K_DEV = 4'h1,
    K_AHI = 4'h2,
    K_ALO = 4'h4,
    K_DATA = 4'h8
  } word_kind_e;
endpackage : eeprom_pkg

//--- design/pin_sync.sv
// two flip-flop synchroniser for pins that change outside sys_clk
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins and their synchronised copy
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // ==========================================================
  // only the second stage reads the first
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= INIT;
      q <= INIT;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : pin_sync
`default_nettype wire

//--- design/word_fifo.sv
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH)
    $error("word_fifo depth must be a power of two");

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW:0] wr_q, wr_d, rd_q, rd_d;
  logic do_wr, do_rd;

  // ==========================================================
  // pointers carry one extra bit so full and empty differ
  always_comb
  begin
    in_ready = (wr_q ^ rd_q) != {1'b1, {PW{1'b0}}};
    out_valid = wr_q != rd_q;
    out_data = mem_q[rd_q[PW-1:0]];
    do_wr = in_valid && in_ready;
    do_rd = out_valid && out_ready;
    wr_d = wr_q + (PW+1)'(do_wr);
    rd_d = rd_q + (PW+1)'(do_rd);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // storage needs no reset, empty pointers hide it
  always_ff @(posedge clk)
  begin
    if (do_wr)
      mem_q[wr_q[PW-1:0]] <= in_data;
  end
endmodule : word_fifo
`default_nettype wire

//--- design/serial_eeprom.sv
// two-wire serial eeprom target: framing, addressing, page write, reads
//
// How it works
// - sample data on clock rise, shift read data out after clock fall
// - unconnected strap pins count as low in the address compare
// - data line is open drain: pulled low or released, never driven high
// - write-protect high blocks all programming; reads are unaffected
// - 14-bit word address, 256 pages of 64 bytes
// - data falling while clock high is start; commands begin with start
// - data rising while clock high is stop; write stop leads to programming
// - eight-bit words, acknowledged by pulling data low on ninth clock
// - standby after reset, after read stop, after programming ends
// - device word accepted only when its top four bits are 1010
// - bits one to three must match straps, else standby without ack
// - last device word bit gives direction: one reads, zero writes
// - byte write is two address words, one data word, then stop
// - while programming, all bus activity is ignored
// - page write takes up to 63 more data words before stop
// - only low six address bits advance per data word, wrapping in page
// - no acknowledge while programming, normal acknowledge afterwards
// - self-timed programming ends within 5 ms
// - address counter keeps last address plus one for current reads
// - acknowledged reads continue sequentially, wrapping to zero
// - repeated start after address words drops the write, runs new command
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom
  import eeprom_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // two-wire bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // straps and protection
  input wire logic [STRAP_W-1:0] chip_select_straps,
  input wire logic write_protect,
  // status
  output logic busy,
  output logic standby
);
  if (PROG_CYCLES < 9)
    $error("PROG_CYCLES too small");

  localparam logic [31:0] PROG_LAST = 32'(PROG_CYCLES - 1);

  logic rst_meta_q, rst_n_q;
  logic scl_s, sda_s, wp_s, scl_p_q, sda_p_q;
  logic [STRAP_W-1:0] str_s;
  logic scl_rise, scl_fall, start, stop, match;
  bus_state_e state_q, state_d;
  word_kind_e kind_q, kind_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, rd_byte;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic dir_q, dir_d, got_q, got_d, oe_n_q, oe_n_d;
  logic busy_q, standby_q, sda_out_q;
  logic [31:0] tmr_q, tmr_d;
  logic push, clr, commit, in_ready, out_valid, out_ready;
  logic [FIFO_W-1:0] out_data;
  logic [(1<<PAGE_W)-1:0] mask_q, mask_d;
  logic [7:0] page_q [1<<PAGE_W];
  logic [7:0] mem_q [1<<ADDR_W];

  // ==========================================================
  // reset release
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ==========================================================
  // pin capture; the bus idles high, so start from released lines
  pin_sync #(.W(STRAP_W + 3), .INIT(6'h30)) u_sync (
    .clk(sys_clk),
    .rst_n(rst_n_q),
    .d({scl_in, sda_in, write_protect, chip_select_straps}),
    .q({scl_s, sda_s, wp_s, str_s})
  );

  always_ff @(posedge sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // edges and bus conditions seen by the sequencer
  always_comb
  begin
    scl_rise = scl_s && !scl_p_q;
    scl_fall = !scl_s && scl_p_q;
    start = scl_s && scl_p_q && sda_p_q && !sda_s;
    stop = scl_s && scl_p_q && !sda_p_q && sda_s;
    // straps are pulled down outside, so a floating one compares as zero
    match = sh_q[7:4] == DEV_CODE && sh_q[3:1] == str_s;
    rd_byte = mem_q[addr_q];
  end

  // ==========================================================
  // write data fifo: stalls only while the page buffer is cleared
  assign out_ready = !clr;

  word_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(sys_clk),
    .rst_n(rst_n_q),
    .in_valid(push),
    .in_ready(in_ready),
    .in_data({addr_q[PAGE_W-1:0], sh_q}),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );

  // ==========================================================
  // bus sequencer
  always_comb
  begin
    state_d = state_q;
    kind_d = kind_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    addr_d = addr_q;
    dir_d = dir_q;
    got_d = got_q;
    oe_n_d = oe_n_q;
    tmr_d = tmr_q;
    push = 1'b0;
    clr = 1'b0;
    commit = 1'b0;
    unique case (state_q)
      ST_IDLE:
      begin
      end
      ST_RX:
      begin
        if (scl_rise)
        begin
          sh_d = {sh_q[6:0], sda_s};
          cnt_d = cnt_q + 4'h1;
        end
        else if (scl_fall && cnt_q == LAST_BIT)
        begin
          cnt_d = 4'h0;
          state_d = ST_ACK;
          oe_n_d = 1'b0;
          unique case (kind_q)
            K_DEV:
            begin
              if (match)
                dir_d = sh_q[0];
              else
              begin
                state_d = ST_IDLE;
                oe_n_d = 1'b1;
              end
            end
            K_AHI:
              addr_d[ADDR_W-1:8] = sh_q[ADDR_W-9:0];
            K_ALO:
            begin
              addr_d[7:0] = sh_q;
              clr = 1'b1;
            end
            K_DATA:
            begin
              if (in_ready)
              begin
                push = 1'b1;
                got_d = 1'b1;
                addr_d[PAGE_W-1:0] = addr_q[PAGE_W-1:0] + 6'h01;
              end
              else
              begin
                // a full fifo refuses the word rather than lose it
                state_d = ST_IDLE;
                oe_n_d = 1'b1;
              end
            end
          endcase
        end
      end
      ST_ACK:
      begin
        if (scl_fall)
        begin
          oe_n_d = 1'b1;
          if (dir_q)
          begin
            state_d = ST_TX;
            sh_d = rd_byte;
            oe_n_d = rd_byte[7];
            addr_d = addr_q + 14'h0001;
          end
          else
          begin
            state_d = ST_RX;
            unique case (kind_q)
              K_DEV: kind_d = K_AHI;
              K_AHI: kind_d = K_ALO;
              K_ALO: kind_d = K_DATA;
              K_DATA: kind_d = K_DATA;
            endcase
          end
        end
      end
      ST_TX:
      begin
        if (scl_fall)
        begin
          if (cnt_q == LAST_SHIFT)
          begin
            cnt_d = 4'h0;
            oe_n_d = 1'b1;
            state_d = ST_RACK;
          end
          else
          begin
            sh_d = {sh_q[6:0], 1'b0};
            oe_n_d = sh_q[6];
            cnt_d = cnt_q + 4'h1;
          end
        end
      end
      ST_RACK:
      begin
        if (scl_rise && sda_s)
          state_d = ST_IDLE;
        else if (scl_fall)
        begin
          state_d = ST_TX;
          sh_d = rd_byte;
          oe_n_d = rd_byte[7];
          addr_d = addr_q + 14'h0001;
        end
      end
      ST_PROG:
      begin
        if (tmr_q != PROG_LAST)
          tmr_d = tmr_q + 32'h1;
        else if (!out_valid)
        begin
          commit = 1'b1;
          state_d = ST_IDLE;
          tmr_d = 32'h0;
        end
      end
    endcase
    // bus conditions; the programming state hears none of them
    if (state_q != ST_PROG)
    begin
      if (start)
      begin
        state_d = ST_RX;
        kind_d = K_DEV;
        cnt_d = 4'h0;
        got_d = 1'b0;
        oe_n_d = 1'b1;
      end
      else if (stop)
      begin
        oe_n_d = 1'b1;
        cnt_d = 4'h0;
        got_d = 1'b0;
        if (got_q && !wp_s)
          state_d = ST_PROG;
        else
          state_d = ST_IDLE;
      end
    end
  end

  // page mask follows the fifo drain
  always_comb
  begin
    mask_d = mask_q;
    if (clr)
      mask_d = '0;
    else if (out_valid)
      mask_d[out_data[FIFO_W-1:8]] = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q <= ST_IDLE;
      kind_q <= K_DEV;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      addr_q <= '0;
      dir_q <= 1'b0;
      got_q <= 1'b0;
      oe_n_q <= 1'b1;
      tmr_q <= 32'h0;
      mask_q <= '0;
      busy_q <= 1'b0;
      standby_q <= 1'b1;
      sda_out_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      kind_q <= kind_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      addr_q <= addr_d;
      dir_q <= dir_d;
      got_q <= got_d;
      oe_n_q <= oe_n_d;
      tmr_q <= tmr_d;
      mask_q <= mask_d;
      busy_q <= state_d == ST_PROG;
      standby_q <= state_d == ST_IDLE;
      sda_out_q <= 1'b0; // open drain only ever pulls low
    end
  end

  // ==========================================================
  // page buffer and array; only whole buffered bytes reach the array
  always_ff @(posedge sys_clk)
  begin
    if (out_valid && out_ready)
      page_q[out_data[FIFO_W-1:8]] <= out_data[7:0];
    if (commit)
    begin
      for (int i = 0; i < (1 << PAGE_W); i++)
      begin
        if (mask_q[i])
          mem_q[{addr_q[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= page_q[i];
      end
    end
  end

  assign sda_out = sda_out_q;
  assign sda_oe_n = oe_n_q;
  assign busy = busy_q;
  assign standby = standby_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n_q);

  sequence s_dev_miss;
    state_q == ST_RX && kind_q == K_DEV && cnt_q == LAST_BIT && scl_fall && !match;
  endsequence

  sequence s_dev_hit;
    state_q == ST_RX && kind_q == K_DEV && cnt_q == LAST_BIT && scl_fall && match;
  endsequence

  a_addr_miss: assert property (s_dev_miss |=> state_q == ST_IDLE && oe_n_q)
    else $error("mismatched device word not released");
  a_addr_ack: assert property (s_dev_hit |=> !oe_n_q && dir_q == $past(sh_q[0]))
    else $error("matched device word not acknowledged");
  a_prog_quiet: assert property (busy_q |-> oe_n_q)
    else $error("data line driven while programming");
  a_prog_bound: assert property (tmr_q <= PROG_LAST)
    else $error("programming timer overran");
  a_wp_block: assert property (stop && wp_s && state_q != ST_PROG |=> !busy_q)
    else $error("programming began under write protect");
  a_page_wrap: assert property (push |=> addr_q[ADDR_W-1:PAGE_W] ==
    $past(addr_q[ADDR_W-1:PAGE_W]) && addr_q[PAGE_W-1:0] ==
    $past(addr_q[PAGE_W-1:0]) + 6'h01)
    else $error("page address did not wrap");
  a_start_drop: assert property (start && state_q != ST_PROG |=> !got_q)
    else $error("pending write kept across start");
  a_tx_edge: assert property (state_q == ST_TX && $changed(oe_n_q) |-> $past(scl_fall))
    else $error("read data moved off a clock fall");
  a_prog_hold: assert property ($rose(busy_q) |-> busy_q [*8])
    else $error("programming ended too soon");
endmodule : serial_eeprom
`default_nettype wire

//--- sim/bus_ctrl_model.sv
// behavioural two-wire bus controller: clock and open-drain data
`timescale 1ns/1ps
`default_nettype none
module bus_ctrl_model (
  // clock
  input wire logic clk,
  // bus wires, data released means 1
  output logic scl,
  output logic sda_drv,
  input wire logic sda_line
);
  // ==========
  // idle bus: clock stands high, data released
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt
  // one bit, 5 clocks low then 3 high; data moves two clocks after the fall
  task automatic bit_io(input logic b, output logic s);
    scl = 1'b0;
    wt(2);
    sda_drv = b;
    wt(3);
    scl = 1'b1;
    wt(2);
    s = sda_line;
    wt(1);
  endtask : bit_io
  // data falls with clock high
  task automatic start_cond;
    scl = 1'b0;
    wt(2);
    sda_drv = 1'b1;
    wt(3);
    scl = 1'b1;
    wt(4);
    sda_drv = 1'b0;
    wt(4);
  endtask : start_cond
  // data rises with clock high, then the clock stands still
  task automatic stop_cond;
    scl = 1'b0;
    wt(2);
    sda_drv = 1'b0;
    wt(3);
    scl = 1'b1;
    wt(4);
    sda_drv = 1'b1;
    wt(4);
  endtask : stop_cond
  // msb first, the line is released in the ninth clock for the answer
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : send_byte
  // last byte of a read is refused so the device stops sending
  task automatic recv_byte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(~ack, s);
  endtask : recv_byte
endmodule : bus_ctrl_model
`default_nettype wire

//--- sim/tb_serial_eeprom.sv
// self-checking bench for the serial eeprom target
`timescale 1ns/1ps
`default_nettype none
module tb_serial_eeprom
  import eeprom_pkg::*;
;
  // ==========
  // programming shortened but long enough to poll inside it
  localparam int PC = 200;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic scl, sda_drv, sda_line, sda_out, sda_oe_n, write_protect, busy, standby;
  logic [STRAP_W-1:0] straps;
  int bad_count = 0;
  int checked = 0;
  int busy_run = 0;
  int ptr = 0;
  logic [31:0] seed = 32'hbc875cf2;
  logic [7:0] mem [int];
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (busy === 1'b1) busy_run++;
  // wired-and of both drivers with the pull-up
  assign sda_line = sda_drv & (sda_oe_n | sda_out);
  serial_eeprom #(.PROG_CYCLES(PC)) dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .chip_select_straps(straps),
    .write_protect(write_protect), .busy(busy), .standby(standby));
  bus_ctrl_model m (.clk(sys_clk), .scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));
  // ==========
  // helpers and comparisons
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [7:0] dw(input logic rd);
    return {DEV_CODE, straps, rd};
  endfunction : dw
  task automatic chk_bit(input string what, input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_bit
  task automatic chk_byte(input string what, input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_byte
  task automatic complete_run;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  // ==========
  // bus sequences with the model kept alongside
  task automatic addr_phase(input logic [13:0] a);
    logic ack;
    m.start_cond();
    m.send_byte(dw(1'b0), ack);
    chk_bit("dev ack", ack, 1'b1);
    m.send_byte({2'b00, a[13:8]}, ack);
    chk_bit("addr hi ack", ack, 1'b1);
    m.send_byte(a[7:0], ack);
    chk_bit("addr lo ack", ack, 1'b1);
  endtask : addr_phase
  task automatic wr(input logic [13:0] a, input int n);
    logic ack;
    logic [7:0] d;
    addr_phase(a);
    for (int i = 0; i < n; i++)
    begin
      d = 8'(rnd());
      m.send_byte(d, ack);
      chk_bit("data ack", ack, 1'b1);
      if (write_protect !== 1'b1) mem[{a[13:6], 6'(int'(a[5:0]) + i)}] = d;
    end
    busy_run = 0;
    m.stop_cond();
    m.wt(2);
    chk_bit("busy", busy, n > 0 && write_protect === 1'b0);
    chk_bit("standby", standby, n == 0 || write_protect === 1'b1);
  endtask : wr
  // polling is refused while busy and answered once idle
  task automatic poll_done;
    logic ack;
    int n;
    m.start_cond();
    m.send_byte(dw(1'b0), ack);
    chk_bit("poll busy", ack, 1'b0);
    m.stop_cond();
    n = 0;
    while (busy === 1'b1 && n < 2 * PC)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk_bit("prog time", busy_run inside {[PC - 2:PC + 2]}, 1'b1);
    chk_bit("standby", standby, 1'b1);
    m.start_cond();
    m.send_byte(dw(1'b0), ack);
    chk_bit("poll idle", ack, 1'b1);
    m.stop_cond();
    m.wt(2);
    chk_bit("no data no prog", busy, 1'b0);
  endtask : poll_done
  // mode 0 random read, 1 with a dropped data word, 2 current address
  task automatic rd(input logic [13:0] a, input int n, input int mode);
    logic ack;
    logic [7:0] d;
    if (mode == 2)
      a = 14'(ptr);
    else
      addr_phase(a);
    if (mode == 1)
    begin
      // the dropped word is still acknowledged and advances the page offset
      m.send_byte(8'(rnd()), ack);
      chk_bit("dropped data ack", ack, 1'b1);
      a[5:0] = a[5:0] + 6'h01;
    end
    m.start_cond();
    m.send_byte(dw(1'b1), ack);
    chk_bit("read dev ack", ack, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      m.recv_byte(i < n - 1, d);
      chk_byte("read data", d, mem[(int'(a) + i) % 16384]);
    end
    m.stop_cond();
    ptr = (int'(a) + n) % 16384;
    m.wt(2);
    chk_bit("idle after read", busy === 1'b0 && standby === 1'b1, 1'b1);
  endtask : rd
  // ==========
  // main sequence and watchdog
  initial
  begin
    #1000000;
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end
  initial
  begin
    logic ack;
    straps = 3'(rnd());
    write_protect = 1'b0;
    repeat (6) @(negedge sys_clk);
    reset_n = 1'b1;
    m.wt(6);
    wr(14'h0000, 1);
    poll_done();
    $display("test byte write done");
    wr(14'h3ffe, 66);
    poll_done();
    $display("test page write done");
    rd(14'h3fc0, 63, 1);
    rd(14'h0000, 1, 2);
    $display("test reads done");
    write_protect = 1'b1;
    wr(14'h0000, 1);
    rd(14'h0000, 1, 0);
    write_protect = 1'b0;
    $display("test write protect done");
    // every strap pattern, then the same with a wrong type code
    for (int s = 0; s < 16; s++)
    begin
      m.start_cond();
      m.send_byte({(s < 8 ? DEV_CODE : DEV_CODE ^ (4'(rnd()) | 4'h1)), 3'(s), 1'b0}, ack);
      chk_bit("select", ack, s < 8 && 3'(s) == straps);
      m.stop_cond();
      m.wt(2);
      chk_bit("standby", standby, 1'b1);
    end
    $display("test addressing done");
    complete_run();
  end
endmodule : tb_serial_eeprom
`default_nettype wire
